// ===== rtl/ccr_cal_path.sv
// Calibration datapath: source select, DC removal, offset subtract and gain scaling
`timescale 1ns/1ps
module ccr_cal_path import ccr_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic signed [23:0] sampleIn,
  input wire logic sampleValid,
  input wire logic [1:0] inputSelect,
  input wire logic dcFilterOff,
  input wire logic globalDcOn,
  input wire logic signed [23:0] offsetWord,
  input wire logic [23:0] gainWord,
  output logic signed [23:0] resultOut,
  output logic resultValid
);

  logic signed [23:0] srcValue;
  logic signed [31:0] dcAcc;
  logic signed [23:0] dcEstimate;
  logic signed [24:0] afterDc;
  logic signed [25:0] afterOffset;
  logic signed [50:0] product;
  logic signed [27:0] scaled;
  logic signed [23:0] next_result;
  logic dcActive;

  // Conversion source chosen per code
  always_comb begin
    case (inputSelect)
      SEL_PINS: srcValue = sampleIn;
      SEL_SHORT: srcValue = '0;
      SEL_POS_TEST: srcValue = TEST_POS_LEVEL;
      SEL_NEG_TEST: srcValue = TEST_NEG_LEVEL;
      default: srcValue = sampleIn;
    endcase
  end

  // Channel bit overrides the global setting only to switch the filter off
  assign dcActive = globalDcOn && !dcFilterOff;
  assign dcEstimate = 24'(dcAcc >>> DC_SHIFT);
  assign afterDc = dcActive ? (25'(srcValue) - 25'(dcEstimate)) : 25'(srcValue);

  // Offset then gain, using the words current with this sample
  assign afterOffset = 26'(afterDc) - 26'(offsetWord);
  assign product = 51'(afterOffset) * $signed({27'h000_0000, gainWord});
  assign scaled = 28'(product >>> GAIN_FRAC_BITS);

  // Saturate so a large gain cannot wrap the sign
  always_comb begin
    if (scaled > 28'sh07F_FFFF) begin
      next_result = 24'sh7F_FFFF;
    end else if (scaled < -28'sh080_0000) begin
      next_result = 24'sh80_0000;
    end else begin
      next_result = scaled[23:0];
    end
  end

  // DC estimate tracks the filtered output; cleared while bypassed
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dcAcc <= '0;
    end else if (!dcActive) begin
      dcAcc <= '0;
    end else if (sampleValid) begin
      dcAcc <= dcAcc + 32'(afterDc);
    end
  end

  // One-cycle result register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      resultOut <= '0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= sampleValid;
      if (sampleValid) begin
        resultOut <= next_result;
      end
    end
  end

  a_result_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
    sampleValid |=> resultValid)
    else $error("result did not follow sample by one cycle");

  a_short_unity: assert property (@(posedge core_clk) disable iff (!rst_b)
    sampleValid && inputSelect == SEL_SHORT && !dcActive && offsetWord == 24'sh00_0000 |=> resultOut == 24'sh00_0000)
    else $error("shorted input with zero offset gave nonzero result");

  a_unity_gain: assert property (@(posedge core_clk) disable iff (!rst_b)
    sampleValid && !dcActive && inputSelect == SEL_PINS && gainWord == 24'h80_0000
    && offsetWord == 24'sh00_0000 |=> resultOut == $past(sampleIn))
    else $error("unity gain did not pass the sample unchanged");

endmodule : ccr_cal_path

// ===== rtl/ccr_pkg.sv
// Package: register map, field layout, reset values and test codes of the channel calibration bank
package ccr_pkg;

  // Register indices; the byte address on APB is four times the index
  localparam logic [7:0] IDX_CH2_GAIN_LOWER = 8'h17;
  localparam logic [7:0] IDX_CH3_CONFIG = 8'h18;
  localparam logic [7:0] IDX_CH3_OFFSET_UPPER = 8'h19;
  localparam logic [7:0] IDX_CH3_OFFSET_LOWER = 8'h1A;
  localparam logic [7:0] IDX_CH3_GAIN_UPPER = 8'h1B;
  localparam logic [7:0] IDX_CH3_GAIN_LOWER = 8'h1C;

  // APB geometry
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;

  // Configuration word fields
  localparam int PHASE_MSB = 15;
  localparam int PHASE_LSB = 6;
  localparam int RSVD_MSB = 5;
  localparam int RSVD_LSB = 3;
  localparam int DC_OFF_BIT = 2;
  localparam int SEL_MSB = 1;
  localparam int SEL_LSB = 0;
  // Lower calibration registers keep their eight bits in the upper byte
  localparam int LO_MSB = 15;
  localparam int LO_LSB = 8;

  // Reset values
  localparam logic [9:0] PHASE_RESET = 10'h000;
  localparam logic DC_OFF_RESET = 1'b0;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [15:0] OFFSET_HI_RESET = 16'h0000;
  localparam logic [7:0] OFFSET_LO_RESET = 8'h00;
  localparam logic [15:0] GAIN_HI_RESET = 16'h8000;
  localparam logic [7:0] GAIN_LO_RESET = 8'h00;
  localparam logic [7:0] CH2_GAIN_LO_RESET = 8'h00;

  // Input selector codes
  localparam logic [1:0] SEL_PINS = 2'h0;
  localparam logic [1:0] SEL_SHORT = 2'h1;
  localparam logic [1:0] SEL_POS_TEST = 2'h2;
  localparam logic [1:0] SEL_NEG_TEST = 2'h3;

  // DC test signal levels, arbitrary design values
  localparam logic signed [23:0] TEST_POS_LEVEL = 24'h20_0000;
  localparam logic signed [23:0] TEST_NEG_LEVEL = 24'hE0_0000;

  // Gain word of unity: 2.0 spans the full 24-bit range
  localparam int GAIN_FRAC_BITS = 23;
  // DC filter estimate smoothing shift
  localparam int DC_SHIFT = 8;

endpackage : ccr_pkg

// ===== rtl/ccr_regs.sv
// Channel calibration and configuration registers on APB, with the calibrated sample path
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module ccr_regs import ccr_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [23:0] ch3Sample,
  input wire logic ch3SampleValid,
  input wire logic globalDcFilterSetting,
  output logic signed [23:0] ch3Result,
  output logic ch3ResultValid,
  output logic [9:0] ch3PhaseDelay,
  output logic ch3DcFilterOff,
  output logic [1:0] ch3InputSelect
);

  logic [15:0] ch3OffsetHi;
  logic [7:0] ch3OffsetLo;
  logic [15:0] ch3GainHi;
  logic [7:0] ch3GainLo;
  logic [7:0] ch2GainLo;
  logic [7:0] regIndex;
  logic highClear;
  logic mapped;
  logic accessPhase;
  logic wrHit;
  logic [15:0] readValue;

  // Address decode: word index, nothing mapped above the index range
  assign regIndex = paddr[IDX_MSB:IDX_LSB];
  assign highClear = (paddr[ADDR_W-1:IDX_MSB+1] == '0);

  always_comb begin
    mapped = 1'b0;
    if (highClear) begin
      case (regIndex)
        IDX_CH2_GAIN_LOWER: mapped = 1'b1;
        IDX_CH3_CONFIG: mapped = 1'b1;
        IDX_CH3_OFFSET_UPPER: mapped = 1'b1;
        IDX_CH3_OFFSET_LOWER: mapped = 1'b1;
        IDX_CH3_GAIN_UPPER: mapped = 1'b1;
        IDX_CH3_GAIN_LOWER: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // One wait state keeps pready and prdata straight from flops
  assign accessPhase = psel && penable;
  assign wrHit = accessPhase && pready && pwrite && mapped;

  // Read mux; reserved bits and bits above 15 come back as zero
  always_comb begin
    readValue = 16'h0000;
    if (highClear) begin
      case (regIndex)
        IDX_CH3_CONFIG: readValue = {ch3PhaseDelay, 3'b000, ch3DcFilterOff, ch3InputSelect};
        IDX_CH3_OFFSET_UPPER: readValue = ch3OffsetHi;
        IDX_CH3_OFFSET_LOWER: readValue = {ch3OffsetLo, 8'h00};
        IDX_CH3_GAIN_UPPER: readValue = ch3GainHi;
        IDX_CH3_GAIN_LOWER: readValue = {ch3GainLo, 8'h00};
        IDX_CH2_GAIN_LOWER: readValue = {ch2GainLo, 8'h00};
        default: readValue = 16'h0000;
      endcase
    end
  end

  // Bus answer: pready pulses for one cycle in each access phase
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (accessPhase && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= (pwrite || !mapped) ? 32'h0000_0000 : {16'h0000, readValue};
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration word; reserved bits 5:3 hold no storage
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch3PhaseDelay <= PHASE_RESET;
      ch3DcFilterOff <= DC_OFF_RESET;
      ch3InputSelect <= SEL_RESET;
    end else if (wrHit && regIndex == IDX_CH3_CONFIG) begin
      if (pstrb[1]) begin
        ch3PhaseDelay[9:2] <= pwdata[PHASE_MSB:PHASE_LSB+2];
      end
      if (pstrb[0]) begin
        ch3PhaseDelay[1:0] <= pwdata[PHASE_LSB+1:PHASE_LSB];
        ch3DcFilterOff <= pwdata[DC_OFF_BIT];
        ch3InputSelect <= pwdata[SEL_MSB:SEL_LSB];
      end
    end
  end

  // Offset correction, upper sixteen bits
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch3OffsetHi <= OFFSET_HI_RESET;
    end else if (wrHit && regIndex == IDX_CH3_OFFSET_UPPER) begin
      if (pstrb[1]) begin
        ch3OffsetHi[15:8] <= pwdata[15:8];
      end
      if (pstrb[0]) begin
        ch3OffsetHi[7:0] <= pwdata[7:0];
      end
    end
  end

  // Offset correction, lowest byte; low lane is read-only zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch3OffsetLo <= OFFSET_LO_RESET;
    end else if (wrHit && regIndex == IDX_CH3_OFFSET_LOWER && pstrb[1]) begin
      ch3OffsetLo <= pwdata[LO_MSB:LO_LSB];
    end
  end

  // Gain correction, upper sixteen bits; reset gives unity
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch3GainHi <= GAIN_HI_RESET;
    end else if (wrHit && regIndex == IDX_CH3_GAIN_UPPER) begin
      if (pstrb[1]) begin
        ch3GainHi[15:8] <= pwdata[15:8];
      end
      if (pstrb[0]) begin
        ch3GainHi[7:0] <= pwdata[7:0];
      end
    end
  end

  // Gain correction, lowest byte
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch3GainLo <= GAIN_LO_RESET;
    end else if (wrHit && regIndex == IDX_CH3_GAIN_LOWER && pstrb[1]) begin
      ch3GainLo <= pwdata[LO_MSB:LO_LSB];
    end
  end

  // Second channel lowest gain byte; stored only, that datapath lives elsewhere
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ch2GainLo <= CH2_GAIN_LO_RESET;
    end else if (wrHit && regIndex == IDX_CH2_GAIN_LOWER && pstrb[1]) begin
      ch2GainLo <= pwdata[LO_MSB:LO_LSB];
    end
  end

  // Datapath sees the registers live, so a write applies from the next sample
  ccr_cal_path u_cal_path (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sampleIn(ch3Sample),
    .sampleValid(ch3SampleValid),
    .inputSelect(ch3InputSelect),
    .dcFilterOff(ch3DcFilterOff),
    .globalDcOn(globalDcFilterSetting),
    .offsetWord($signed({ch3OffsetHi, ch3OffsetLo})),
    .gainWord({ch3GainHi, ch3GainLo}),
    .resultOut(ch3Result),
    .resultValid(ch3ResultValid)
  );

  // Checks next to the logic they guard

  a_phase_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH3_CONFIG && pstrb[1:0] == 2'b11 |=> ch3PhaseDelay == $past(pwdata[15:6]))
    else $error("phase delay did not take the written bits 15:6");

  a_cfg_reserved_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    accessPhase && !pready && !pwrite && mapped && regIndex == IDX_CH3_CONFIG
    |=> pready && prdata[5:3] == 3'b000 && prdata[31:16] == 16'h0000)
    else $error("reserved configuration bits did not read zero");

  a_lower_reserved_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    accessPhase && !pready && !pwrite && mapped
    && (regIndex == IDX_CH3_OFFSET_LOWER || regIndex == IDX_CH3_GAIN_LOWER || regIndex == IDX_CH2_GAIN_LOWER)
    |=> prdata[7:0] == 8'h00)
    else $error("low byte of a lower calibration register did not read zero");

  a_dc_off_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH3_CONFIG && pstrb[0] |=> ch3DcFilterOff == $past(pwdata[2]))
    else $error("filter-off bit did not follow the write");

  a_select_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH3_CONFIG && pstrb[0] |=> ch3InputSelect == $past(pwdata[1:0]))
    else $error("input select did not follow the write");

  a_offset_hi_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH3_OFFSET_UPPER && pstrb[1:0] == 2'b11 |=> ch3OffsetHi == $past(pwdata[15:0]))
    else $error("upper offset did not take the written word");

  a_offset_lo_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH3_OFFSET_LOWER && pstrb[1] |=> ch3OffsetLo == $past(pwdata[15:8]))
    else $error("lower offset did not take bits 15:8");

  a_gain_reset: assert property (@(posedge core_clk)
    !rst_b |=> ch3GainHi == GAIN_HI_RESET && ch3GainLo == GAIN_LO_RESET)
    else $error("gain did not reset to unity");

  a_gain_lo_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH3_GAIN_LOWER && pstrb[1] |=> ch3GainLo == $past(pwdata[15:8]))
    else $error("lower gain did not take bits 15:8");

  a_ch2_gain_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrHit && regIndex == IDX_CH2_GAIN_LOWER && pstrb[1] |=> ch2GainLo == $past(pwdata[15:8]))
    else $error("second channel lower gain did not take bits 15:8");

  a_map_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    accessPhase && !pready && highClear && regIndex >= IDX_CH2_GAIN_LOWER && regIndex <= IDX_CH3_GAIN_LOWER
    |=> pready && !pslverr)
    else $error("mapped index answered with an error");

  a_ready_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    pready |=> !pready)
    else $error("pready stood for more than one cycle");

endmodule : ccr_regs

// ===== sim/ccr_regs_tb.sv
// Self-checking bench for the channel calibration register bank and its sample path
`timescale 1ns/1ps
module ccr_regs_tb import ccr_pkg::*;;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, er, erW;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic signed [23:0] ch3Sample, ch3Result;
  logic ch3SampleValid, globalDcFilterSetting, ch3ResultValid, ch3DcFilterOff;
  logic [9:0] ch3PhaseDelay;
  logic [1:0] ch3InputSelect;
  int errors = 0;
  int numChecks = 0;
  int cycles = 0;

  typedef struct {logic [11:0] addr; logic [15:0] wd; logic [3:0] st; logic [15:0] exp; logic err;} ccr_row_t;
  // Rows run in order; the low-lane config row relies on the first config row
  ccr_row_t rows [9] = '{
    '{12'h060, 16'hFFFF, 4'h3, 16'hFFC7, 1'b0},
    '{12'h064, 16'hA5C3, 4'h3, 16'hA5C3, 1'b0},
    '{12'h068, 16'hFFFF, 4'h3, 16'hFF00, 1'b0},
    '{12'h06C, 16'h1234, 4'h3, 16'h1234, 1'b0},
    '{12'h070, 16'hABCD, 4'h3, 16'hAB00, 1'b0},
    '{12'h05C, 16'h5A77, 4'h3, 16'h5A00, 1'b0},
    '{12'h060, 16'h1234, 4'h1, 16'hFF04, 1'b0},
    '{12'h460, 16'hFFFF, 4'h3, 16'h0000, 1'b1},
    '{12'h074, 16'hFFFF, 4'h3, 16'h0000, 1'b1}};
  logic [11:0] rstAddr [6] = '{12'h05C, 12'h060, 12'h064, 12'h068, 12'h06C, 12'h070};
  logic [15:0] rstVal [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  logic [23:0] selExp [4] = '{24'h12_3456, 24'h00_0000, TEST_POS_LEVEL, TEST_NEG_LEVEL};

  ccr_regs u_ccr_regs (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch3Sample(ch3Sample), .ch3SampleValid(ch3SampleValid), .globalDcFilterSetting(globalDcFilterSetting),
    .ch3Result(ch3Result), .ch3ResultValid(ch3ResultValid), .ch3PhaseDelay(ch3PhaseDelay),
    .ch3DcFilterOff(ch3DcFilterOff), .ch3InputSelect(ch3InputSelect)
  );

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Comparison and mismatch report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One APB transfer; reads pready in the active region, so the pre-edge value is seen
  // Waits as long as the slave needs; only the run timeout ends a hung wait
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] wd, input logic [3:0] st,
                     output logic [31:0] rdat, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {16'h0000, wd};
    pstrb <= st;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] addr, input logic [15:0] wd, input logic [3:0] st);
    apb(1'b1, addr, wd, st, rd, erW);
  endtask : wr

  // One sample in, result expected exactly one cycle later
  task automatic smp(input logic [23:0] s, input logic [23:0] exp, input string what);
    @(posedge core_clk);
    ch3SampleValid <= 1'b1;
    ch3Sample <= s;
    @(posedge core_clk);
    ch3SampleValid <= 1'b0;
    @(posedge core_clk);
    chk({31'h0, ch3ResultValid}, 32'h0000_0001, "result strobe");
    chk({8'h00, ch3Result}, {8'h00, exp}, what);
  endtask : smp

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
  endtask : do_reset

  task complete_run;
    $display("checks %0d mismatches %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Hang guard, well above the roughly two hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      $display("unexpected at %0t: run timeout", $time);
      complete_run();
    end
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    ch3Sample = '0;
    ch3SampleValid = 1'b0;
    globalDcFilterSetting = 1'b0;
    do_reset();
    // Register cases and two unmapped addresses: write, then read back
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wd, rows[i].st);
      apb(1'b0, rows[i].addr, 16'h0000, 4'h0, rd, er);
      chk({30'h0, erW, er}, {30'h0, rows[i].err, rows[i].err}, "error flags");
      chk(rd, {16'h0000, rows[i].exp}, "readback");
    end
    @(posedge core_clk);
    chk({22'h0, ch3PhaseDelay}, {22'h0, rows[6].exp[PHASE_MSB:PHASE_LSB]}, "phase port");
    chk({29'h0, ch3DcFilterOff, ch3InputSelect}, {29'h0, rows[6].exp[2:0]}, "mode ports");
    $display("test register rows done");
    // Reset in mid-run restores every stored value
    do_reset();
    chk({19'h0, ch3PhaseDelay, ch3DcFilterOff, ch3InputSelect}, 32'h0000_0000, "config ports");
    foreach (rstAddr[i]) begin
      apb(1'b0, rstAddr[i], 16'h0000, 4'h0, rd, er);
      chk(rd, {16'h0000, rstVal[i]}, "reset value");
    end
    $display("test reset values done");
    // Every source code with unity gain and zero offset
    for (int s = 0; s < 4; s++) begin
      wr(12'h060, 16'(s), 4'h1);
      @(posedge core_clk);
      chk({30'h0, ch3InputSelect}, 32'(s), "select port");
      smp(24'h12_3456, selExp[s], "source value");
    end
    $display("test input select done");
    // Per-channel filter override, then deferral to the global setting
    globalDcFilterSetting <= 1'b1;
    wr(12'h060, 16'h0004, 4'h1);
    smp(24'h01_0000, 24'h01_0000, "filter off");
    smp(24'h01_0000, 24'h01_0000, "filter off again");
    wr(12'h060, 16'h0000, 4'h1);
    smp(24'h01_0000, 24'h01_0000, "filter first");
    smp(24'h01_0000, 24'h00_FF00, "filter second");
    globalDcFilterSetting <= 1'b0;
    $display("test dc filter done");
    // Offset and gain assembled from both halves, signs included
    wr(12'h064, 16'h0001, 4'h3);
    wr(12'h06C, 16'h4000, 4'h3);
    smp(24'h00_1100, 24'h00_0800, "offset and half gain");
    wr(12'h064, 16'hFFFF, 4'h3);
    wr(12'h068, 16'hFF00, 4'h2);
    smp(24'h00_0101, 24'h00_0081, "negative offset");
    wr(12'h070, 16'h8000, 4'h2);
    smp(24'h3F_FFFF, 24'h20_0040, "gain low byte");
    $display("test calibration done");
    complete_run();
  end
endmodule : ccr_regs_tb
